// ### pkg/dtu_pkg.sv
// Shared constants, types and encodings for the data transfer instruction unit
package dtu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  // One CPU state is 0.20 us
  localparam int unsigned STATE_TIME_NS = 200;
  localparam int unsigned STATE_CLKS    = (STATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned M1_BASE_STATES         = 4;
  localparam int unsigned MX_BASE_STATES         = 3;
  localparam int unsigned WAIT_STATES_PER_ACCESS = 2;
  localparam logic [2:0]  M1_STATES = 3'(M1_BASE_STATES + WAIT_STATES_PER_ACCESS);
  localparam logic [2:0]  MX_STATES = 3'(MX_BASE_STATES + WAIT_STATES_PER_ACCESS);

  ////////////////////////////////////////////////////////////////////////////
  // Register field encodings
  localparam logic [2:0] REG_B = 3'h0;
  localparam logic [2:0] REG_C = 3'h1;
  localparam logic [2:0] REG_D = 3'h2;
  localparam logic [2:0] REG_E = 3'h3;
  localparam logic [2:0] REG_H = 3'h4;
  localparam logic [2:0] REG_L = 3'h5;
  localparam logic [2:0] REG_M = 3'h6;
  localparam logic [2:0] REG_A = 3'h7;

  localparam logic [1:0] PAIR_BC = 2'h0;
  localparam logic [1:0] PAIR_DE = 2'h1;
  localparam logic [1:0] PAIR_HL = 2'h2;
  localparam logic [1:0] PAIR_SP = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Opcode patterns and field positions
  localparam logic [1:0] GRP_COPY     = 2'h1;
  localparam logic [1:0] GRP_LOW      = 2'h0;
  localparam logic [2:0] LOW_IMM_TAIL = 3'h6;
  localparam logic [3:0] LOW_PAIR_TAIL = 4'h1;
  localparam logic [7:0] OPC_HALT_SLOT          = 8'h76;
  localparam logic [7:0] OPC_ACC_DIRECT_LOAD    = 8'h3a;
  localparam logic [7:0] OPC_ACC_DIRECT_STORE   = 8'h32;
  localparam logic [7:0] OPC_HL_DIRECT_LOAD     = 8'h2a;
  localparam logic [7:0] OPC_HL_DIRECT_STORE    = 8'h22;

  localparam int unsigned GRP_MSB  = 7;
  localparam int unsigned GRP_LSB  = 6;
  localparam int unsigned DEST_MSB = 5;
  localparam int unsigned DEST_LSB = 3;
  localparam int unsigned SRC_MSB  = 2;
  localparam int unsigned SRC_LSB  = 0;
  localparam int unsigned PAIR_MSB = 5;
  localparam int unsigned PAIR_LSB = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [15:0] SP_RESET    = 16'h0000;
  localparam logic [7:0]  REG_RESET   = 8'h00;
  localparam logic [4:0]  FLAGS_RESET = 5'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [4:0] {
    MC_FETCH = 5'b00001,
    MC_OPND1 = 5'b00010,
    MC_OPND2 = 5'b00100,
    MC_MEM1  = 5'b01000,
    MC_MEM2  = 5'b10000
  } mc_e;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mem_req_s;

endpackage

// ### hw/cpu_state_timer.sv
// Divider that marks the last clock of every CPU state
`timescale 1ns/1ps
`default_nettype none

module cpu_state_timer #(
  parameter int unsigned STATE_CLKS = dtu_pkg::STATE_CLKS
) (
  input  wire logic i_clk_sys,
  input  wire logic i_nrst,
  input  wire logic i_ce,
  output logic      o_tick
);

  localparam int unsigned CW   = (STATE_CLKS > 1) ? $clog2(STATE_CLKS) : 1;
  localparam logic [CW-1:0] LAST = CW'(STATE_CLKS - 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (i_ce) begin
      cnt_next = (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign o_tick = i_ce && (cnt_reg == LAST);

endmodule

`default_nettype wire

// ### hw/cpu_reg_file.sv
// Eight-slot byte register file with two write ports
`timescale 1ns/1ps
`default_nettype none

module cpu_reg_file #(
  parameter int unsigned ENTRIES = 8
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  input  wire logic       i_ce,
  input  wire logic [2:0] i_rd_idx,
  input  wire logic       i_wa_en,
  input  wire logic [2:0] i_wa_idx,
  input  wire logic [7:0] i_wa_data,
  input  wire logic       i_wb_en,
  input  wire logic [2:0] i_wb_idx,
  input  wire logic [7:0] i_wb_data,
  output logic [7:0]      o_rd_data,
  output logic [7:0]      o_acc,
  output logic [7:0]      o_h,
  output logic [7:0]      o_l
);

  logic [7:0] regs_reg  [ENTRIES];
  logic [7:0] regs_next [ENTRIES];

  for (genvar i = 0; i < ENTRIES; i++) begin : g_entry
    always_comb begin
      regs_next[i] = regs_reg[i];
      if (i_wa_en && (i_wa_idx == 3'(i))) begin
        regs_next[i] = i_wa_data;
      end else if (i_wb_en && (i_wb_idx == 3'(i))) begin
        regs_next[i] = i_wb_data;
      end
    end

    always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
        regs_reg[i] <= dtu_pkg::REG_RESET;
      end else if (i_ce) begin
        regs_reg[i] <= regs_next[i];
      end
    end
  end

  assign o_rd_data = regs_reg[i_rd_idx];
  assign o_acc     = regs_reg[dtu_pkg::REG_A];
  assign o_h       = regs_reg[dtu_pkg::REG_H];
  assign o_l       = regs_reg[dtu_pkg::REG_L];

endmodule

`default_nettype wire

// ### hw/data_transfer_instruction_unit.sv
// Fetch, decode and machine cycle sequencing for the data transfer instructions
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - One CPU state lasts 0.2 us, counted as clock cycles.
// - No data transfer instruction changes any of the five flags.
// - Register copy: source into destination, one machine cycle, 6 states.
// - Copy from memory at H/L into a register, two cycles, 11 states.
// - Copy a register to memory at H/L, opcode 01110sss, 11 states.
// - Immediate copy: byte 2 into register, opcode 00ddd110, 11 states.
// - Immediate copy to memory at H/L, three cycles, 16 states.
// - Pair load: byte 3 into high, byte 2 into low register, 16 states.
// - Direct accumulator load from address byte3:byte2, 21 states.
// - Direct accumulator store to address byte3:byte2, 21 states.
// - Direct H/L store: L to address, H to address plus one, 26 states.
// - Each memory access adds its wait states to the base states.
module data_transfer_instruction_unit #(
  parameter int unsigned  STATE_CLKS = dtu_pkg::STATE_CLKS,
  parameter logic [15:0]  PC_INIT    = dtu_pkg::PC_RESET
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  input  wire logic       i_ce,
  input  wire logic [7:0] i_mem_rdata,
  output var dtu_pkg::mem_req_s o_mem,
  output logic [15:0]     o_pc,
  output logic [15:0]     o_sp,
  output logic [4:0]      o_flags,
  output logic            o_instr_done,
  output logic [5:0]      o_instr_states,
  output logic            o_unsupported
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  dtu_pkg::mc_e      mc_reg;
  dtu_pkg::mc_e      mc_next;
  dtu_pkg::mem_req_s mem_reg;
  dtu_pkg::mem_req_s mem_next;
  logic [7:0]        op_reg;
  logic [7:0]        op_next;
  logic [7:0]        byte2_reg;
  logic [7:0]        byte2_next;
  logic [15:0]       addr_reg;
  logic [15:0]       addr_next;
  logic [15:0]       pc_reg;
  logic [15:0]       pc_next;
  logic [15:0]       sp_reg;
  logic [15:0]       sp_next;
  logic [4:0]        flags_reg;
  logic [4:0]        flags_next;
  logic [2:0]        st_cnt_reg;
  logic [2:0]        st_cnt_next;
  logic [5:0]        ist_reg;
  logic [5:0]        ist_next;
  logic [5:0]        ist_out_reg;
  logic [5:0]        ist_out_next;
  logic              done_reg;
  logic              done_next;
  logic              unsup_reg;
  logic              unsup_next;
  logic              tick;
  logic [2:0]        mc_len;
  logic              cycle_end;
  logic              finish;
  logic [7:0]        op;
  logic [2:0]        rd_idx;
  logic [7:0]        rd_data;
  logic [7:0]        acc;
  logic [7:0]        reg_h;
  logic [7:0]        reg_l;
  logic [15:0]       hl;
  logic [15:0]       word;
  logic              wa_en;
  logic [2:0]        wa_idx;
  logic [7:0]        wa_data;
  logic              wb_en;
  logic [2:0]        wb_idx;
  logic [7:0]        wb_data;

  ////////////////////////////////////////////////////////////////////////////
  // Submodules
  cpu_state_timer #(
    .STATE_CLKS (STATE_CLKS)
  ) u_timer (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_ce      (i_ce),
    .o_tick    (tick)
  );
  cpu_reg_file #(
    .ENTRIES (8)
  ) u_regs (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_ce      (i_ce),
    .i_rd_idx  (rd_idx),
    .i_wa_en   (wa_en),
    .i_wa_idx  (wa_idx),
    .i_wa_data (wa_data),
    .i_wb_en   (wb_en),
    .i_wb_idx  (wb_idx),
    .i_wb_data (wb_data),
    .o_rd_data (rd_data),
    .o_acc     (acc),
    .o_h       (reg_h),
    .o_l       (reg_l)
  );

  assign hl   = {reg_h, reg_l};
  assign word = {i_mem_rdata, byte2_reg};
  // Opcode byte is still on the bus at the end of the fetch cycle
  assign op     = (mc_reg == dtu_pkg::MC_FETCH) ? i_mem_rdata : op_reg;
  assign rd_idx = op[dtu_pkg::SRC_MSB:dtu_pkg::SRC_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // Machine cycle length
  always_comb begin
    mc_len = (mc_reg == dtu_pkg::MC_FETCH) ? dtu_pkg::M1_STATES : dtu_pkg::MX_STATES;
    cycle_end = tick && (st_cnt_reg == mc_len - 3'h1);
    st_cnt_next = st_cnt_reg;
    if (tick) begin
      st_cnt_next = cycle_end ? 3'h0 : st_cnt_reg + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    mc_next    = mc_reg;
    mem_next   = mem_reg;
    op_next    = op_reg;
    byte2_next = byte2_reg;
    addr_next  = addr_reg;
    pc_next    = pc_reg;
    sp_next    = sp_reg;
    flags_next = flags_reg;
    finish     = 1'b0;
    unsup_next = 1'b0;
    wa_en      = 1'b0;
    wa_idx     = op[dtu_pkg::DEST_MSB:dtu_pkg::DEST_LSB];
    wa_data    = rd_data;
    wb_en      = 1'b0;
    wb_idx     = dtu_pkg::REG_C;
    wb_data    = byte2_reg;
    if (cycle_end) begin
      mem_next.rd = 1'b0;
      mem_next.wr = 1'b0;
      case (mc_reg)
        dtu_pkg::MC_FETCH: begin
          op_next = op;
          pc_next = pc_reg + 16'h0001;
          if (op[dtu_pkg::GRP_MSB:dtu_pkg::GRP_LSB] == dtu_pkg::GRP_COPY && op != dtu_pkg::OPC_HALT_SLOT) begin
            if (op[dtu_pkg::SRC_MSB:dtu_pkg::SRC_LSB] == dtu_pkg::REG_M) begin
              mc_next      = dtu_pkg::MC_MEM1;
              mem_next.rd  = 1'b1;
              mem_next.addr = hl;
            end else if (op[dtu_pkg::DEST_MSB:dtu_pkg::DEST_LSB] == dtu_pkg::REG_M) begin
              mc_next        = dtu_pkg::MC_MEM1;
              mem_next.wr    = 1'b1;
              mem_next.addr  = hl;
              mem_next.wdata = rd_data;
            end else begin
              wa_en  = 1'b1;
              finish = 1'b1;
            end
          end else if ((op[dtu_pkg::GRP_MSB:dtu_pkg::GRP_LSB] == dtu_pkg::GRP_LOW &&
                        (op[dtu_pkg::SRC_MSB:dtu_pkg::SRC_LSB] == dtu_pkg::LOW_IMM_TAIL ||
                         op[3:0] == dtu_pkg::LOW_PAIR_TAIL)) ||
                       op == dtu_pkg::OPC_ACC_DIRECT_LOAD || op == dtu_pkg::OPC_ACC_DIRECT_STORE ||
                       op == dtu_pkg::OPC_HL_DIRECT_LOAD || op == dtu_pkg::OPC_HL_DIRECT_STORE) begin
            mc_next       = dtu_pkg::MC_OPND1;
            mem_next.rd   = 1'b1;
            mem_next.addr = pc_next;
          end else begin
            // Other groups belong to other units; this one retires them in one cycle
            unsup_next = 1'b1;
            finish     = 1'b1;
          end
        end
        dtu_pkg::MC_OPND1: begin
          byte2_next = i_mem_rdata;
          pc_next    = pc_reg + 16'h0001;
          if (op_reg[dtu_pkg::SRC_MSB:dtu_pkg::SRC_LSB] == dtu_pkg::LOW_IMM_TAIL &&
              op_reg[dtu_pkg::GRP_MSB:dtu_pkg::GRP_LSB] == dtu_pkg::GRP_LOW) begin
            if (op_reg[dtu_pkg::DEST_MSB:dtu_pkg::DEST_LSB] == dtu_pkg::REG_M) begin
              mc_next        = dtu_pkg::MC_MEM1;
              mem_next.wr    = 1'b1;
              mem_next.addr  = hl;
              mem_next.wdata = i_mem_rdata;
            end else begin
              wa_en   = 1'b1;
              wa_data = i_mem_rdata;
              finish  = 1'b1;
            end
          end else begin
            mc_next       = dtu_pkg::MC_OPND2;
            mem_next.rd   = 1'b1;
            mem_next.addr = pc_next;
          end
        end
        dtu_pkg::MC_OPND2: begin
          pc_next   = pc_reg + 16'h0001;
          addr_next = word;
          if (op_reg[3:0] == dtu_pkg::LOW_PAIR_TAIL) begin
            finish = 1'b1;
            if (op_reg[dtu_pkg::PAIR_MSB:dtu_pkg::PAIR_LSB] == dtu_pkg::PAIR_SP) begin
              sp_next = word;
            end else begin
              // Pair code doubles as the high register's field: B/C, D/E, H/L
              wa_en   = 1'b1;
              wa_idx  = {op_reg[dtu_pkg::PAIR_MSB:dtu_pkg::PAIR_LSB], 1'b0};
              wa_data = i_mem_rdata;
              wb_en   = 1'b1;
              wb_idx  = {op_reg[dtu_pkg::PAIR_MSB:dtu_pkg::PAIR_LSB], 1'b1};
            end
          end else begin
            mc_next       = dtu_pkg::MC_MEM1;
            mem_next.addr = word;
            if (op_reg == dtu_pkg::OPC_ACC_DIRECT_STORE) begin
              mem_next.wr    = 1'b1;
              mem_next.wdata = acc;
            end else if (op_reg == dtu_pkg::OPC_HL_DIRECT_STORE) begin
              mem_next.wr    = 1'b1;
              mem_next.wdata = reg_l;
            end else begin
              mem_next.rd = 1'b1;
            end
          end
        end
        dtu_pkg::MC_MEM1: begin
          if (op_reg == dtu_pkg::OPC_HL_DIRECT_LOAD || op_reg == dtu_pkg::OPC_HL_DIRECT_STORE) begin
            mc_next        = dtu_pkg::MC_MEM2;
            mem_next.rd    = (op_reg == dtu_pkg::OPC_HL_DIRECT_LOAD);
            mem_next.wr    = (op_reg == dtu_pkg::OPC_HL_DIRECT_STORE);
            mem_next.addr  = addr_reg + 16'h0001;
            mem_next.wdata = reg_h;
            wa_en          = (op_reg == dtu_pkg::OPC_HL_DIRECT_LOAD);
            wa_idx         = dtu_pkg::REG_L;
            wa_data        = i_mem_rdata;
          end else begin
            finish = 1'b1;
            if (op_reg == dtu_pkg::OPC_ACC_DIRECT_LOAD) begin
              wa_en   = 1'b1;
              wa_idx  = dtu_pkg::REG_A;
              wa_data = i_mem_rdata;
            end else if (op_reg[dtu_pkg::GRP_MSB:dtu_pkg::GRP_LSB] == dtu_pkg::GRP_COPY &&
                         op_reg[dtu_pkg::SRC_MSB:dtu_pkg::SRC_LSB] == dtu_pkg::REG_M) begin
              wa_en   = 1'b1;
              wa_data = i_mem_rdata;
            end
          end
        end
        dtu_pkg::MC_MEM2: begin
          finish = 1'b1;
          if (op_reg == dtu_pkg::OPC_HL_DIRECT_LOAD) begin
            wa_en   = 1'b1;
            wa_idx  = dtu_pkg::REG_H;
            wa_data = i_mem_rdata;
          end
        end
        default: begin
          finish = 1'b1;
        end
      endcase
      if (finish) begin
        mc_next       = dtu_pkg::MC_FETCH;
        mem_next.rd   = 1'b1;
        mem_next.addr = pc_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction state counter, reported with the completion pulse
  always_comb begin
    ist_next     = ist_reg + 6'(tick);
    ist_out_next = ist_out_reg;
    done_next    = 1'b0;
    if (finish) begin
      ist_next     = 6'h00;
      ist_out_next = ist_reg + 6'h01;
      done_next    = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      mc_reg      <= dtu_pkg::MC_FETCH;
      mem_reg     <= '{rd: 1'b1, wr: 1'b0, addr: PC_INIT, wdata: 8'h00};
      op_reg      <= 8'h00;
      byte2_reg   <= 8'h00;
      addr_reg    <= 16'h0000;
      pc_reg      <= PC_INIT;
      sp_reg      <= dtu_pkg::SP_RESET;
      flags_reg   <= dtu_pkg::FLAGS_RESET;
      st_cnt_reg  <= 3'h0;
      ist_reg     <= 6'h00;
      ist_out_reg <= 6'h00;
      done_reg    <= 1'b0;
      unsup_reg   <= 1'b0;
    end else if (i_ce) begin
      mc_reg      <= mc_next;
      mem_reg     <= mem_next;
      op_reg      <= op_next;
      byte2_reg   <= byte2_next;
      addr_reg    <= addr_next;
      pc_reg      <= pc_next;
      sp_reg      <= sp_next;
      flags_reg   <= flags_next;
      st_cnt_reg  <= st_cnt_next;
      ist_reg     <= ist_next;
      ist_out_reg <= ist_out_next;
      done_reg    <= done_next;
      unsup_reg   <= unsup_next;
    end
  end

  assign o_mem          = mem_reg;
  assign o_pc           = pc_reg;
  assign o_sp           = sp_reg;
  assign o_flags        = flags_reg;
  assign o_instr_done   = done_reg;
  assign o_instr_states = ist_out_reg;
  assign o_unsupported  = unsup_reg;

endmodule

`default_nettype wire

// ### dv/dtu_mem_model.sv
// Behavioural program and data memory on the processor bus
`timescale 1ns/1ps
`default_nettype none

module dtu_mem_model (
  input  wire logic              i_clk_sys,
  input  wire dtu_pkg::mem_req_s i_mem,
  output logic [7:0]             o_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_reg;

  initial begin
    for (int a = 0; a < 65536; a++) begin
      mem[a] = 8'h00;
    end
    last_reg = 8'h00;
  end

  task automatic put(input logic [15:0] a, input logic [7:0] d);
    mem[a] = d;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Writes commit on every clock with wr high; repeats carry the same data
  always @(posedge i_clk_sys) begin
    if (i_mem.wr) begin
      mem[i_mem.addr] <= i_mem.wdata;
    end
    if (i_mem.rd) begin
      last_reg <= mem[i_mem.addr];
    end
  end

  // Released bus shows the inverse of the last byte so a stale sample is caught
  assign o_rdata = i_mem.rd ? mem[i_mem.addr] : ~last_reg;
endmodule

`default_nettype wire

// ### dv/dtu_chk.sv
// Port level assertions for the data transfer unit
`timescale 1ns/1ps
`default_nettype none

module dtu_chk #(
  parameter int unsigned STATE_CLKS = 8,
  parameter logic [15:0] PC_INIT    = 16'h0000
) (
  input wire logic              i_clk_sys,
  input wire logic              i_nrst,
  input wire logic              i_ce,
  input wire logic [7:0]        i_mem_rdata,
  input wire dtu_pkg::mem_req_s o_mem,
  input wire logic [15:0]       o_pc,
  input wire logic [15:0]       o_sp,
  input wire logic [4:0]        o_flags,
  input wire logic              o_instr_done,
  input wire logic [5:0]        o_instr_states,
  input wire logic              o_unsupported
);
  localparam int unsigned FETCH_LEN = 6 * STATE_CLKS;
  localparam int unsigned MC_LEN    = 5 * STATE_CLKS;
  logic [25:0] mem_q_reg;
  logic [15:0] run_reg;
  logic [15:0] ilen_reg;
  logic        done_q_reg;
  logic        ch;
  logic        rise;

  assign ch   = (o_mem != mem_q_reg);
  assign rise = o_instr_done && !done_q_reg;

  // Only enabled clocks count, so a frozen unit does not stretch the figures
  always_ff @(posedge i_clk_sys) begin
    mem_q_reg  <= o_mem;
    done_q_reg <= o_instr_done;
    if (!i_nrst) begin
      run_reg  <= 16'h0000;
      ilen_reg <= 16'h0000;
    end else begin
      run_reg  <= ch ? 16'(i_ce) : run_reg + 16'(i_ce);
      ilen_reg <= rise ? 16'(i_ce) : ilen_reg + 16'(i_ce);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);

  sequence s_next_fetch;
    ch && o_mem.rd && !o_mem.wr && o_mem.addr == o_pc;
  endsequence
  sequence s_pulse_end;
    !o_instr_done;
  endsequence

  a_flags_constant: assert property (o_flags == dtu_pkg::FLAGS_RESET)
    else $error("flags moved");
  a_rd_wr_excl: assert property (!(o_mem.rd && o_mem.wr))
    else $error("read and write together");
  a_cycle_length: assert property (ch |-> run_reg == FETCH_LEN || run_reg == MC_LEN)
    else $error("machine cycle length wrong");
  a_states_measured: assert property ($rose(o_instr_done) |-> ilen_reg == o_instr_states * STATE_CLKS)
    else $error("state count differs from elapsed clocks");
  a_states_legal: assert property ($rose(o_instr_done) |-> o_instr_states inside {6, 11, 16, 21, 26})
    else $error("illegal state count");
  a_done_fetch: assert property ($rose(o_instr_done) |-> s_next_fetch)
    else $error("done without next fetch");
  a_done_pulse: assert property (o_instr_done && i_ce |=> s_pulse_end)
    else $error("done longer than one clock");
  a_unsup_retire: assert property ($rose(o_unsupported) |->
    o_instr_done && o_instr_states == 6'h06 && o_pc == $past(o_pc) + 16'h0001)
    else $error("unsupported opcode retired wrongly");
  a_sp_at_end: assert property ($changed(o_sp) |-> $rose(o_instr_done))
    else $error("stack pointer changed mid instruction");
endmodule

bind data_transfer_instruction_unit dtu_chk #(.STATE_CLKS(STATE_CLKS), .PC_INIT(PC_INIT)) u_dtu_chk (
  .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_ce(i_ce), .i_mem_rdata(i_mem_rdata), .o_mem(o_mem),
  .o_pc(o_pc), .o_sp(o_sp), .o_flags(o_flags), .o_instr_done(o_instr_done),
  .o_instr_states(o_instr_states), .o_unsupported(o_unsupported));

`default_nettype wire

// ### dv/data_transfer_instruction_unit_bench.sv
// Self-checking bench running a transfer program through the unit
`timescale 1ns/1ps
`default_nettype none

module data_transfer_instruction_unit_bench;
  // Two clocks per state so the state divider really counts
  localparam int unsigned SC = 2;
  localparam logic [287:0] PROG = {
    128'h21_40_01_06_5a_48_71_7e_32_50_01_36_c3_3a_40_01,
    160'h2a_60_01_22_70_01_31_ef_be_32_72_01_76_77_70_11_34_12_73_72};
  logic              i_clk_sys;
  logic              i_nrst;
  logic              i_ce;
  logic [7:0]        rdata;
  dtu_pkg::mem_req_s mem_req;
  logic [15:0]       o_pc;
  logic [15:0]       o_sp;
  logic [4:0]        o_flags;
  logic              o_instr_done;
  logic [5:0]        o_instr_states;
  logic              o_unsupported;
  int                n_errors;
  int                n_checks;

  data_transfer_instruction_unit #(.STATE_CLKS(SC)) u_data_transfer_instruction_unit (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_ce(i_ce), .i_mem_rdata(rdata), .o_mem(mem_req),
    .o_pc(o_pc), .o_sp(o_sp), .o_flags(o_flags), .o_instr_done(o_instr_done),
    .o_instr_states(o_instr_states), .o_unsupported(o_unsupported));

  dtu_mem_model u_dtu_mem_model (.i_clk_sys(i_clk_sys), .i_mem(mem_req), .o_rdata(rdata));

  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic memchk(input logic [15:0] a, input logic [7:0] e);
    check(32'(u_dtu_mem_model.mem[a]), 32'(e));
  endtask

  // Bounded wait so a lost done pulse shows as a mismatch, not a hang
  task automatic step(input logic [5:0] st, input logic [15:0] pc, input logic un);
    int k;
    k = 0;
    do begin
      @(negedge i_clk_sys);
      k++;
    end while (o_instr_done !== 1'b1 && k < 400);
    check(32'(o_instr_done), 32'h1);
    check(32'(o_instr_states), 32'(st));
    check(32'(o_pc), 32'(pc));
    check(32'(o_unsupported), 32'(un));
    check(32'(o_flags), 32'(dtu_pkg::FLAGS_RESET));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    repeat (10) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    check(32'(mem_req), {6'h00, 26'h2000000});
    check({o_pc, o_sp}, 32'h0);
    check({o_flags, o_instr_done, o_unsupported}, 32'h0);
    @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    $display("test reset done");
  endtask

  task automatic t_reg_moves();
    step(6'h10, 16'h0003, 1'b0);
    step(6'h0b, 16'h0005, 1'b0);
    step(6'h06, 16'h0006, 1'b0);
    step(6'h0b, 16'h0007, 1'b0);
    memchk(16'h0140, 8'h5a);
    $display("test reg_moves done");
  endtask

  task automatic t_mem_moves();
    step(6'h0b, 16'h0008, 1'b0);
    step(6'h15, 16'h000b, 1'b0);
    memchk(16'h0150, 8'h5a);
    step(6'h10, 16'h000d, 1'b0);
    memchk(16'h0140, 8'hc3);
    step(6'h15, 16'h0010, 1'b0);
    $display("test mem_moves done");
  endtask

  task automatic t_hl_direct();
    step(6'h1a, 16'h0013, 1'b0);
    step(6'h1a, 16'h0016, 1'b0);
    memchk(16'h0170, 8'h11);
    memchk(16'h0171, 8'h22);
    step(6'h10, 16'h0019, 1'b0);
    check(32'(o_sp), 32'h0000beef);
    step(6'h15, 16'h001c, 1'b0);
    memchk(16'h0172, 8'hc3);
    $display("test hl_direct done");
  endtask

  task automatic t_unsupported();
    step(6'h06, 16'h001d, 1'b1);
    step(6'h0b, 16'h001e, 1'b0);
    memchk(16'h2211, 8'hc3);
    $display("test unsupported done");
  endtask

  // Clock enable dropped inside a fetch cycle must freeze bus, program counter and pulses
  task automatic t_freeze();
    logic [25:0] snap;
    logic [15:0] pcs;
    logic        moved;
    moved = 1'b0;
    @(posedge i_clk_sys);
    i_ce <= 1'b0;
    @(negedge i_clk_sys);
    snap = mem_req;
    pcs  = o_pc;
    repeat (20) begin
      @(negedge i_clk_sys);
      if (mem_req !== snap || o_pc !== pcs || o_instr_done !== 1'b0) moved = 1'b1;
    end
    check(32'(moved), 32'h0);
    @(posedge i_clk_sys);
    i_ce <= 1'b1;
    step(6'h0b, 16'h001f, 1'b0);
    memchk(16'h2211, 8'h5a);
    $display("test freeze done");
  endtask

  // Pair load into D/E, then each half written out through H/L
  task automatic t_pair_load();
    step(6'h10, 16'h0022, 1'b0);
    step(6'h0b, 16'h0023, 1'b0);
    memchk(16'h2211, 8'h34);
    step(6'h0b, 16'h0024, 1'b0);
    memchk(16'h2211, 8'h12);
    $display("test pair_load done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge i_clk_sys);
    n_errors++;
    conclude();
  end

  initial begin
    i_nrst   = 1'b0;
    i_ce     = 1'b1;
    n_errors = 0;
    n_checks = 0;
    @(negedge i_clk_sys);
    for (int i = 0; i < 36; i++) begin
      u_dtu_mem_model.put(16'(i), PROG[287 - 8 * i -: 8]);
    end
    u_dtu_mem_model.put(16'h0160, 8'h11);
    u_dtu_mem_model.put(16'h0161, 8'h22);
    t_reset();
    t_reg_moves();
    t_mem_moves();
    t_hl_direct();
    t_unsupported();
    t_freeze();
    t_pair_load();
    conclude();
  end
endmodule

`default_nettype wire
